// ===== rps_pkg.sv
// Constants shared by the reset pin state and strap control block
`default_nettype none
package rps_pkg;
  // Timing
  localparam int CLK_PERIOD_NS     = 4;
  localparam int RST_PULL_LIMIT_NS = 1500000;
  localparam int RST_PULL_LIMIT_CYC = RST_PULL_LIMIT_NS / CLK_PERIOD_NS;
  localparam int STRAP_DELAY_NS    = 2000000;
  localparam int STRAP_DELAY_CYC   = (STRAP_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W             = 20;
  // Register port
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam logic [ADDR_W-1:0] REG_CTRL    = 4'h0;
  localparam logic [ADDR_W-1:0] REG_HOST_PU = 4'h1;
  localparam logic [ADDR_W-1:0] REG_ANT     = 4'h2;
  localparam logic [ADDR_W-1:0] REG_GP_OUT  = 4'h3;
  localparam logic [ADDR_W-1:0] REG_GP_OE   = 4'h4;
  localparam logic [ADDR_W-1:0] REG_GP_PU   = 4'h5;
  localparam logic [ADDR_W-1:0] REG_GP_PD   = 4'h6;
  localparam logic [ADDR_W-1:0] REG_STATUS  = 4'h7;
  localparam logic [ADDR_W-1:0] REG_GP_IN   = 4'h8;
  // Control fields
  localparam int CTRL_W          = 3;
  localparam int CTRL_RST_WEAK   = 0;
  localparam int CTRL_REG_PD_DIS = 1;
  localparam int CTRL_PWM_PD_DIS = 2;
  // Status fields
  localparam int ST_HOST_SPI  = 0;
  localparam int ST_CLK_PP    = 1;
  localparam int ST_DONE      = 2;
  localparam int ST_RST_PULL  = 3;
  localparam int ST_RST_HELD  = 4;
  localparam int ST_REG_REQ   = 5;
  localparam int ST_PWM_REQ   = 6;
  // Antenna switch pins
  localparam int           ANT_W      = 4;
  localparam logic [3:0]   ANT_PU_RST = 4'h1;
  localparam logic [3:0]   ANT_PD_RST = 4'hE;
  localparam logic [3:0]   ANT_ALL    = 4'hF;
  // Strap
  localparam int STRAP_HOST_PIN = 0;
  typedef enum logic [1:0] {
    RPS_DELAY  = 2'b00,
    RPS_SAMPLE = 2'b01,
    RPS_RUN    = 2'b10
  } rps_phase_t;
endpackage
`default_nettype wire

// ===== rps_pin_ctrl.sv
// Reset pin state, pull control and power-on strap sampling
//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////
//
// The address map and the address-and-strobe port are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module rps_pin_ctrl #(
  parameter int GPIO_W         = 8,
  parameter int HOST_PU_W      = 5,
  parameter int STRAP_DELAY    = rps_pkg::STRAP_DELAY_CYC,
  parameter int RST_PULL_LIMIT = rps_pkg::RST_PULL_LIMIT_CYC
) (
  // Clock and power-on reset
  input  wire logic                        ref_clk,
  input  wire logic                        sys_rst,
  // Register port
  input  wire logic [rps_pkg::ADDR_W-1:0]  reg_addr,
  input  wire logic [rps_pkg::DATA_W-1:0]  reg_wdata,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  output var  logic [rps_pkg::DATA_W-1:0]  reg_rdata,
  // External reset pin
  input  wire logic                        wlan_reset_in_low,
  output var  logic                        rst_pin_pmu_pull_dn,
  output var  logic                        rst_pin_weak_pull_dn,
  // Request inputs
  input  wire logic                        ext_regulator_request,
  input  wire logic                        ext_pulse_mode_request,
  output var  logic                        regulator_req_pull_dn,
  output var  logic                        pulse_req_pull_dn,
  // Host interface
  output var  logic [HOST_PU_W-1:0]        host_pin_pull_up,
  output var  logic                        host_mode_spi,
  // Oscillator clock request
  input  wire logic                        clk_needed,
  input  wire logic                        sleep_mode,
  input  wire logic                        strap_clk_push_pull,
  output var  logic                        osc_clock_request,
  output var  logic                        osc_clock_request_oe,
  output var  logic                        osc_clock_request_pull_dn,
  // Antenna switch control
  output var  logic                        antenna_switch_ctl_a,
  output var  logic                        antenna_switch_ctl_b,
  output var  logic                        antenna_switch_ctl_c,
  output var  logic                        antenna_switch_ctl_d,
  output var  logic [rps_pkg::ANT_W-1:0]   ant_switch_oe,
  output var  logic [rps_pkg::ANT_W-1:0]   ant_switch_pull_up,
  output var  logic [rps_pkg::ANT_W-1:0]   ant_switch_pull_dn,
  // General pins
  input  wire logic [GPIO_W-1:0]           gpio_in,
  output var  logic [GPIO_W-1:0]           gpio_out,
  output var  logic [GPIO_W-1:0]           gpio_oe,
  output var  logic [GPIO_W-1:0]           gpio_pull_up,
  output var  logic [GPIO_W-1:0]           gpio_pull_dn,
  output var  logic                        strap_done
);
  import rps_pkg::*;
  localparam logic [CNT_W-1:0] STRAP_LAST = CNT_W'(STRAP_DELAY - 1);
  localparam logic [CNT_W-1:0] PULL_LIMIT = CNT_W'(RST_PULL_LIMIT);
  typedef struct packed {
    logic                 rst_s1;
    logic                 rst_s2;
    logic                 pp_s1;
    logic                 pp_s2;
    logic [1:0]           req_s1;
    logic [1:0]           req_s2;
    logic [GPIO_W-1:0]    gp_s1;
    logic [GPIO_W-1:0]    gp_s2;
    rps_phase_t           phase;
    logic [CNT_W-1:0]     cnt;
    logic [CNT_W-1:0]     pull_wait;
    logic                 host_spi;
    logic                 clk_pp;
    logic                 done;
    logic [CTRL_W-1:0]    ctrl;
    logic [HOST_PU_W-1:0] host_pu_dis;
    logic [ANT_W-1:0]     ant_val;
    logic [GPIO_W-1:0]    gp_out;
    logic [GPIO_W-1:0]    gp_oe;
    logic [GPIO_W-1:0]    gp_pu;
    logic [GPIO_W-1:0]    gp_pd;
    logic [DATA_W-1:0]    rdata;
    logic                 rst_pd;
    logic                 rst_weak;
    logic                 regpd;
    logic                 pwmpd;
    logic [HOST_PU_W-1:0] host_pu;
    logic                 clk_o;
    logic                 clk_oe;
    logic                 clk_pd;
    logic [ANT_W-1:0]     ant_o;
    logic [ANT_W-1:0]     ant_oe;
    logic [ANT_W-1:0]     ant_pu;
    logic [ANT_W-1:0]     ant_pd;
    logic [GPIO_W-1:0]    gpo;
    logic [GPIO_W-1:0]    gpo_oe;
    logic [GPIO_W-1:0]    gpo_pu;
    logic [GPIO_W-1:0]    gpo_pd;
  } rps_state_t;
  rps_state_t r_ff;
  rps_state_t nxt_r;
  logic       in_rst;
  logic       clk_req;
  //////////////////////////////////////////////////////////////////////////
  always_comb begin
    nxt_r = r_ff;
    // First stages feed only the second stages
    nxt_r.rst_s1 = wlan_reset_in_low;
    nxt_r.rst_s2 = r_ff.rst_s1;
    nxt_r.pp_s1  = strap_clk_push_pull;
    nxt_r.pp_s2  = r_ff.pp_s1;
    nxt_r.req_s1 = {ext_pulse_mode_request, ext_regulator_request};
    nxt_r.req_s2 = r_ff.req_s1;
    nxt_r.gp_s1  = gpio_in;
    nxt_r.gp_s2  = r_ff.gp_s1;
    in_rst  = !r_ff.rst_s2;
    clk_req = clk_needed && !sleep_mode;
    // Strap timer runs once per power-on reset
    unique case (r_ff.phase)
      RPS_DELAY: begin
        nxt_r.cnt = r_ff.cnt + CNT_W'(1);
        if (r_ff.cnt >= STRAP_LAST) begin
          nxt_r.phase = RPS_SAMPLE;
        end
      end
      RPS_SAMPLE: begin
        nxt_r.host_spi = r_ff.gp_s2[STRAP_HOST_PIN];
        nxt_r.clk_pp   = r_ff.pp_s2;
        nxt_r.done     = 1'h1;
        nxt_r.phase    = RPS_RUN;
      end
      RPS_RUN: begin
        nxt_r.phase = RPS_RUN;
      end
      default: begin
        nxt_r.phase = RPS_DELAY;
      end
    endcase
    // Register writes
    if (reg_wr) begin
      unique case (reg_addr)
        REG_CTRL:    nxt_r.ctrl        = reg_wdata[CTRL_W-1:0];
        REG_HOST_PU: nxt_r.host_pu_dis = reg_wdata[HOST_PU_W-1:0];
        REG_ANT:     nxt_r.ant_val     = reg_wdata[ANT_W-1:0];
        REG_GP_OUT:  nxt_r.gp_out      = reg_wdata[GPIO_W-1:0];
        REG_GP_OE:   nxt_r.gp_oe       = reg_wdata[GPIO_W-1:0];
        REG_GP_PU:   nxt_r.gp_pu       = reg_wdata[GPIO_W-1:0];
        REG_GP_PD:   nxt_r.gp_pd       = reg_wdata[GPIO_W-1:0];
        default: begin
        end
      endcase
    end
    // Read data stand for one cycle only; unmapped reads give zero
    nxt_r.rdata = '0;
    if (reg_rd) begin
      unique case (reg_addr)
        REG_CTRL:    nxt_r.rdata[CTRL_W-1:0]    = r_ff.ctrl;
        REG_HOST_PU: nxt_r.rdata[HOST_PU_W-1:0] = r_ff.host_pu_dis;
        REG_ANT:     nxt_r.rdata[ANT_W-1:0]     = r_ff.ant_val;
        REG_GP_OUT:  nxt_r.rdata[GPIO_W-1:0]    = r_ff.gp_out;
        REG_GP_OE:   nxt_r.rdata[GPIO_W-1:0]    = r_ff.gp_oe;
        REG_GP_PU:   nxt_r.rdata[GPIO_W-1:0]    = r_ff.gp_pu;
        REG_GP_PD:   nxt_r.rdata[GPIO_W-1:0]    = r_ff.gp_pd;
        REG_GP_IN:   nxt_r.rdata[GPIO_W-1:0]    = r_ff.gp_s2;
        REG_STATUS: begin
          nxt_r.rdata[ST_HOST_SPI] = r_ff.host_spi;
          nxt_r.rdata[ST_CLK_PP]   = r_ff.clk_pp;
          nxt_r.rdata[ST_DONE]     = r_ff.done;
          nxt_r.rdata[ST_RST_PULL] = r_ff.rst_pd;
          nxt_r.rdata[ST_RST_HELD] = in_rst;
          nxt_r.rdata[ST_REG_REQ]  = r_ff.req_s2[0];
          nxt_r.rdata[ST_PWM_REQ]  = r_ff.req_s2[1];
        end
        default: begin
        end
      endcase
    end
    // Reset input pulls: PMU pull-down only while reset is held, weak pull-down only after release
    nxt_r.rst_pd   = in_rst;
    nxt_r.rst_weak = !in_rst && !r_ff.rst_pd && r_ff.ctrl[CTRL_RST_WEAK];
    nxt_r.regpd    = in_rst || !r_ff.ctrl[CTRL_REG_PD_DIS];
    nxt_r.pwmpd    = in_rst || !r_ff.ctrl[CTRL_PWM_PD_DIS];
    nxt_r.host_pu  = in_rst ? '0 : ~r_ff.host_pu_dis;
    // Wait counter proves the pull-down release bound
    if (!in_rst && r_ff.rst_pd) begin
      nxt_r.pull_wait = r_ff.pull_wait + CNT_W'(1);
    end else begin
      nxt_r.pull_wait = '0;
    end
    // Clock request; push-pull only once the strap is known
    if (in_rst) begin
      nxt_r.clk_o  = 1'h0;
      nxt_r.clk_oe = 1'h0;
      nxt_r.clk_pd = 1'h1;
    end else if (r_ff.done && r_ff.clk_pp) begin
      nxt_r.clk_o  = clk_req;
      nxt_r.clk_oe = 1'h1;
      nxt_r.clk_pd = 1'h0;
    end else begin
      nxt_r.clk_o  = clk_req;
      nxt_r.clk_oe = clk_req;
      nxt_r.clk_pd = 1'h1;
    end
    // Antenna switch pins
    if (in_rst) begin
      nxt_r.ant_oe = '0;
      nxt_r.ant_pu = ANT_PU_RST;
      nxt_r.ant_pd = ANT_PD_RST;
      nxt_r.ant_o  = '0;
    end else begin
      nxt_r.ant_oe = ANT_ALL;
      nxt_r.ant_pu = '0;
      nxt_r.ant_pd = '0;
      nxt_r.ant_o  = r_ff.ant_val;
    end
    // General pins stay off the strap until sampling ends
    if (in_rst || !r_ff.done) begin
      nxt_r.gpo    = '0;
      nxt_r.gpo_oe = '0;
      nxt_r.gpo_pu = '0;
      nxt_r.gpo_pd = '0;
    end else begin
      nxt_r.gpo    = r_ff.gp_out;
      nxt_r.gpo_oe = r_ff.gp_oe;
      nxt_r.gpo_pu = r_ff.gp_pu;
      nxt_r.gpo_pd = r_ff.gp_pd;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      r_ff        <= '0;
      r_ff.phase  <= RPS_DELAY;
      r_ff.rst_pd <= 1'h1;
      r_ff.regpd  <= 1'h1;
      r_ff.pwmpd  <= 1'h1;
      r_ff.clk_pd <= 1'h1;
      r_ff.ant_pu <= ANT_PU_RST;
      r_ff.ant_pd <= ANT_PD_RST;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign reg_rdata                 = r_ff.rdata;
  assign rst_pin_pmu_pull_dn       = r_ff.rst_pd;
  assign rst_pin_weak_pull_dn      = r_ff.rst_weak;
  assign regulator_req_pull_dn     = r_ff.regpd;
  assign pulse_req_pull_dn         = r_ff.pwmpd;
  assign host_pin_pull_up          = r_ff.host_pu;
  assign host_mode_spi             = r_ff.host_spi;
  assign osc_clock_request         = r_ff.clk_o;
  assign osc_clock_request_oe      = r_ff.clk_oe;
  assign osc_clock_request_pull_dn = r_ff.clk_pd;
  assign antenna_switch_ctl_a      = r_ff.ant_o[0];
  assign antenna_switch_ctl_b      = r_ff.ant_o[1];
  assign antenna_switch_ctl_c      = r_ff.ant_o[2];
  assign antenna_switch_ctl_d      = r_ff.ant_o[3];
  assign ant_switch_oe             = r_ff.ant_oe;
  assign ant_switch_pull_up        = r_ff.ant_pu;
  assign ant_switch_pull_dn        = r_ff.ant_pd;
  assign gpio_out                  = r_ff.gpo;
  assign gpio_oe                   = r_ff.gpo_oe;
  assign gpio_pull_up              = r_ff.gpo_pu;
  assign gpio_pull_dn              = r_ff.gpo_pd;
  assign strap_done                = r_ff.done;

  //////////////////////////////////////////////////////////////////////////
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  sequence rst_release_s;
    $rose(r_ff.rst_s2);
  endsequence
  sequence pull_gone_s;
    ##[1:2] !rst_pin_pmu_pull_dn;
  endsequence

  ant_float_a: assert property (
    !r_ff.rst_s2 |=> ant_switch_oe == '0 && ant_switch_pull_up == ANT_PU_RST
                     && ant_switch_pull_dn == ANT_PD_RST)
    else $error("antenna pins not floating in reset");
  ant_drive_a: assert property (
    r_ff.rst_s2 |=> ant_switch_oe == ANT_ALL && ant_switch_pull_up == '0
                    && ant_switch_pull_dn == '0)
    else $error("antenna pins not driven after reset");
  rst_pull_a: assert property (
    rst_release_s |-> pull_gone_s)
    else $error("reset pull-down not released");
  pull_limit_a: assert property (
    r_ff.pull_wait < PULL_LIMIT)
    else $error("reset pull-down held past limit");
  weak_pull_a: assert property (
    rst_pin_weak_pull_dn |-> !rst_pin_pmu_pull_dn && $past(r_ff.ctrl[CTRL_RST_WEAK]))
    else $error("weak pull-down while not allowed");
  req_pull_a: assert property (
    r_ff.rst_s2 ##1 r_ff.rst_s2 |=>
      regulator_req_pull_dn == !$past(r_ff.ctrl[CTRL_REG_PD_DIS]))
    else $error("regulator request pull mismatch");
  host_pull_a: assert property (
    r_ff.rst_s2 |=> host_pin_pull_up == ~$past(r_ff.host_pu_dis))
    else $error("host pull-up mismatch");
  clk_open_a: assert property (
    r_ff.rst_s2 && !r_ff.clk_pp |=>
      osc_clock_request_pull_dn && osc_clock_request_oe == osc_clock_request)
    else $error("open-source clock request wrong");
  clk_push_a: assert property (
    r_ff.rst_s2 && r_ff.done && r_ff.clk_pp |=>
      osc_clock_request_oe && !osc_clock_request_pull_dn)
    else $error("push-pull clock request wrong");
  clk_sleep_a: assert property (
    sleep_mode |=> !osc_clock_request)
    else $error("clock requested in sleep");
  strap_time_a: assert property (
    $rose(strap_done) |-> $past(r_ff.cnt, 2) >= STRAP_LAST)
    else $error("straps sampled too early");
  gpio_hold_a: assert property (
    !strap_done |=> gpio_oe == '0)
    else $error("general pin driven before sampling");
  strap_keep_a: assert property (
    strap_done |=> strap_done && $stable(host_mode_spi))
    else $error("latched strap changed");
endmodule // rps_pin_ctrl
`default_nettype wire

// ===== rps_board_model.sv
// Board side model: reset line and strap resistors of the host board
`timescale 1ns/10ps
`default_nettype none
module rps_board_model (
  // Bench controls
  input  wire logic ref_clk,
  input  wire logic rst_hold,
  input  wire logic host_sel,
  input  wire logic pp_sel,
  input  wire logic strap_done,
  // Pins toward the device
  output logic      wlan_reset_in_low,
  output logic      strap_host,
  output logic      strap_clk_push_pull
);
  logic churn_ff = 1'b0;
  // Sampled straps are plain pins again, so keep them moving
  always @(posedge ref_clk) churn_ff <= strap_done ? ~churn_ff : 1'b0;
  assign wlan_reset_in_low = ~rst_hold;
  // Unfitted strap reads 0 through its pull-down
  assign strap_host = strap_done ? churn_ff : host_sel;
  assign strap_clk_push_pull = strap_done ? ~churn_ff : pp_sel;
endmodule // rps_board_model
`default_nettype wire

// ===== reset_pin_state_and_strap_control_bench.sv
// Self-checking bench for the reset pin state and strap control block
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end
module reset_pin_state_and_strap_control_bench;
  import rps_pkg::*;
  localparam int SD = 20;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic [DATA_W-1:0] reg_rdata, rd_val;
  logic reg_wr = 1'b0, reg_rd = 1'b0, rst_hold = 1'b1, host_sel = 1'b0, pp_sel = 1'b0;
  logic ext_reg = 1'b0, ext_pwm = 1'b0, clk_needed = 1'b0, sleep_mode = 1'b0;
  logic [6:0] gp_hi = '0;
  logic wlan_n, strap_host, strap_pp, pmu_pd, weak_pd, reg_pd, pwm_pd, spi;
  logic osc, osc_oe, osc_pd, ant_a, ant_b, ant_c, ant_d, done;
  logic [4:0] host_pu;
  logic [3:0] ant_oe, ant_pu, ant_pd;
  logic [7:0] gp_out, gp_oe, gp_pu, gp_pd;
  int n_mismatch = 0, n_tests = 0, cyc = 0;

  always #2 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 6000) begin
      n_mismatch++;
      report_and_stop();
    end
  end

  rps_pin_ctrl #(.GPIO_W(8), .HOST_PU_W(5), .STRAP_DELAY(SD)) uut (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .wlan_reset_in_low(wlan_n),
    .rst_pin_pmu_pull_dn(pmu_pd), .rst_pin_weak_pull_dn(weak_pd),
    .ext_regulator_request(ext_reg), .ext_pulse_mode_request(ext_pwm),
    .regulator_req_pull_dn(reg_pd), .pulse_req_pull_dn(pwm_pd), .host_pin_pull_up(host_pu),
    .host_mode_spi(spi), .clk_needed(clk_needed), .sleep_mode(sleep_mode),
    .strap_clk_push_pull(strap_pp), .osc_clock_request(osc), .osc_clock_request_oe(osc_oe),
    .osc_clock_request_pull_dn(osc_pd), .antenna_switch_ctl_a(ant_a),
    .antenna_switch_ctl_b(ant_b), .antenna_switch_ctl_c(ant_c), .antenna_switch_ctl_d(ant_d),
    .ant_switch_oe(ant_oe), .ant_switch_pull_up(ant_pu), .ant_switch_pull_dn(ant_pd),
    .gpio_in({gp_hi, strap_host}), .gpio_out(gp_out), .gpio_oe(gp_oe), .gpio_pull_up(gp_pu),
    .gpio_pull_dn(gp_pd), .strap_done(done));

  rps_board_model board (.ref_clk(ref_clk), .rst_hold(rst_hold), .host_sel(host_sel),
    .pp_sel(pp_sel), .strap_done(done), .wlan_reset_in_low(wlan_n),
    .strap_host(strap_host), .strap_clk_push_pull(strap_pp));

  task automatic report_and_stop();
    if (n_mismatch == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 rd_val = reg_rdata;
  endtask

  // Pin value, drive enable, pull-down of the clock request
  function automatic logic [2:0] exp_osc(input logic need, input logic slp, input logic pp);
    logic on;
    on = need & ~slp;
    return pp ? {on, 1'b1, 1'b0} : {on, on, 1'b1};
  endfunction

  task automatic chk_held();
    `CHK({ant_oe, ant_pu, ant_pd}, {4'h0, ANT_PU_RST, ANT_PD_RST})
    `CHK({gp_oe, gp_pu, gp_pd}, 24'h000000)
    `CHK({pmu_pd, weak_pd, host_pu}, 7'h40)
    `CHK({reg_pd, pwm_pd}, 2'b11)
  endtask

  task automatic power_on(input logic hs, input logic pp);
    int rel;
    logic [15:0] ctl, hpu, ant, go, goe, gpu, gpd;
    @(posedge ref_clk);
    sys_rst <= 1'b1;
    rst_hold <= 1'b1;
    host_sel <= hs;
    pp_sel <= pp;
    repeat (4) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rel = cyc;
    tick(1);
    chk_held();
    // Reset pin let go early: outputs still wait for the strap sample
    wr(REG_GP_OE, 16'h00FF);
    wr(REG_GP_PU, 16'h00FF);
    rst_hold <= 1'b0;
    tick(4);
    `CHK({gp_oe, gp_pu, pmu_pd}, 17'h00000)
    while (done !== 1'b1 && cyc - rel < 4 * SD) tick(1);
    `CHK(done, 1'b1)
    `CHK((cyc - rel) inside {[SD:SD + 3]}, 1'b1)
    `CHK(spi, hs)
    tick(6);
    `CHK(spi, hs)
    @(posedge ref_clk);
    rst_hold <= 1'b0;
    tick(4);
    `CHK({pmu_pd, ant_oe, ant_pu, ant_pd, host_pu}, {1'b0, ANT_ALL, 8'h00, 5'h1F})
    `CHK({gp_oe, gp_pu, gp_pd}, 24'hFFFF00)
    for (int i = 0; i < 4; i++) begin
      @(posedge ref_clk);
      clk_needed <= i[0];
      sleep_mode <= i[1];
      tick(2);
      `CHK({osc, osc_oe, osc_pd}, exp_osc(i[0], i[1], pp))
    end
    repeat (5) begin
      {ctl, hpu, ant, go} = {$urandom, $urandom};
      {goe, gpu, gpd} = {$urandom, 16'($urandom)};
      @(posedge ref_clk);
      {ext_reg, ext_pwm, clk_needed, sleep_mode, gp_hi} <= 11'($urandom);
      wr(REG_CTRL, ctl);
      wr(REG_HOST_PU, hpu);
      wr(REG_ANT, ant);
      wr(REG_GP_OUT, go);
      wr(REG_GP_OE, goe);
      wr(REG_GP_PU, gpu);
      wr(REG_GP_PD, gpd);
      tick(3);
      `CHK({weak_pd, reg_pd, pwm_pd}, {ctl[0], ~ctl[1], ~ctl[2]})
      `CHK(host_pu, ~hpu[4:0])
      `CHK({ant_d, ant_c, ant_b, ant_a}, ant[3:0])
      `CHK({gp_out, gp_oe, gp_pu, gp_pd}, {go[7:0], goe[7:0], gpu[7:0], gpd[7:0]})
      `CHK({osc, osc_oe, osc_pd}, exp_osc(clk_needed, sleep_mode, pp))
      rd(REG_STATUS);
      `CHK(rd_val, {9'h000, ext_pwm, ext_reg, 2'b00, 1'b1, pp, hs})
      rd(REG_GP_IN);
      `CHK(rd_val[7:1], gp_hi)
    end
    // Unmapped place: write ignored, read gives zero
    wr(4'hF, 16'hFFFF);
    rd(4'hF);
    `CHK(rd_val, 16'h0000)
    rd(REG_ANT);
    `CHK(rd_val, {12'h000, ant[3:0]})
    tick(1);
    `CHK(reg_rdata, 16'h0000)
    @(posedge ref_clk);
    rst_hold <= 1'b1;
    tick(4);
    chk_held();
    `CHK(spi, hs)
  endtask

  initial begin
    void'($urandom(48021));
    power_on(1'b0, 1'b0);
    power_on(1'b1, 1'b1);
    power_on(1'($urandom), 1'($urandom));
    report_and_stop();
  end
endmodule // reset_pin_state_and_strap_control_bench
`default_nettype wire
